// ===== pofc_defines.svh
// register offsets, field positions and reset values of the pwm output stage
`ifndef POFC_DEFINES_SVH
`define POFC_DEFINES_SVH

// register offsets
`define POFC_ADDR_TBCTL    10'h1C0
`define POFC_ADDR_COUNT    10'h1C2
`define POFC_ADDR_PERIOD   10'h1C4
`define POFC_ADDR_EVTCMP   10'h1C6
`define POFC_ADDR_OUTCTL   10'h1C8
`define POFC_ADDR_SECCTL   10'h1CA
`define POFC_ADDR_DEADTIME 10'h1CC
`define POFC_ADDR_FAULT    10'h1D0
`define POFC_ADDR_FORCE    10'h1D4
`define POFC_ADDR_DUTY1    10'h1D6
`define POFC_ADDR_DUTY2    10'h1D8
`define POFC_ADDR_DUTY3    10'h1DA
`define POFC_ADDR_STATUS   10'h1DC

// timebase_ctl_reg fields
`define POFC_TB_RUN_BIT     15
`define POFC_TB_MODE_LSB    0
// timebase_mode_sel encodings
`define POFC_MODE_FREE      2'h0
`define POFC_MODE_SINGLE    2'h2
// event compare fields
`define POFC_EVT_PHASE_BIT  15
// output_control_reg fields
`define POFC_PAIR_MODE_LSB  8
`define POFC_HI_EN_LSB      4
`define POFC_LO_EN_LSB      0
// secondary_control_reg fields
`define POFC_PSC_LSB        8
`define POFC_SYNC_BIT       1
`define POFC_LOCK_BIT       0
// fault_ctl_reg fields
`define POFC_FLT_LVL_LSB    8
`define POFC_FLT_MODE_BIT   7
`define POFC_FLT_EN_LSB     0
// output_force_reg fields
`define POFC_FORCE_SEL_LSB  8
`define POFC_FORCE_LVL_LSB  0
// status fields
`define POFC_ST_FLAG_BIT    0

// reset values and write masks
`define POFC_RST_PERIOD     15'h3FFF
`define POFC_RST_OUTCTL     16'h0077
`define POFC_RST_FORCE      16'h3F00
`define POFC_FORCE_MASK     16'h3F3F
`define POFC_FAULT_MASK     16'h3F87
`define POFC_OUTCTL_MASK    16'h0777

`endif

// ===== pofc_event_trig.sv
// special event trigger postscaler toward the adc
`timescale 1ns/1ps
module pofc_event_trig (
  input  wire logic core_clk,
  input  wire logic rst,
  pofc_evt_if.psc   evt
);

  logic [3:0] ps_cnt_r;
  logic       trig_r;
  logic       ps_done;

  // fire on the n-th match, n = select + 1
  assign ps_done = (ps_cnt_r == evt.ps_sel);

  ////////////////////////////////////////////////////////////////////////////
  // postscale counter; a compare write restarts the ratio
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ps_cnt_r <= 4'h0;
    end else if (evt.clr) begin
      ps_cnt_r <= 4'h0;
    end else if (evt.match) begin
      ps_cnt_r <= ps_done ? 4'h0 : ps_cnt_r + 4'h1;
    end
  end

  // one-cycle trigger pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= evt.match & ps_done & ~evt.clr;
    end
  end

  assign evt.trig = trig_r;

endmodule : pofc_event_trig

// ===== pofc_evt_if.sv
// carrier between the output stage and the event trigger postscaler
`timescale 1ns/1ps
interface pofc_evt_if;
  logic       match;
  logic [3:0] ps_sel;
  logic       clr;
  logic       trig;
  modport src (output match, output ps_sel, output clr, input  trig);
  modport psc (input  match, input  ps_sel, input  clr, output trig);
endinterface : pofc_evt_if

// ===== pofc_far_model.sv
// far side: fault sensor, gate drivers with pull-downs, adc trigger counter
`timescale 1ns/1ps
module pofc_far_model (
  input  wire logic       core_clk,
  input  wire logic       flt_low,
  input  wire logic [2:0] high_side_output,
  input  wire logic [2:0] low_side_output,
  input  wire logic [2:0] high_side_oe,
  input  wire logic [2:0] low_side_oe,
  input  wire logic       adc_trigger,
  output logic            fault_input_n,
  output logic [2:0]      hs_pad,
  output logic [2:0]      ls_pad,
  output logic [7:0]      trig_cnt = 8'h00
);
  // sensor holds the line low until told otherwise; going high ends the fault
  initial fault_input_n = 1'b1;
  always @(posedge core_clk) fault_input_n <= !flt_low;
  // released pins fall to the pull-down, never a stale level
  assign hs_pad = high_side_output & high_side_oe;
  assign ls_pad = low_side_output & low_side_oe;
  // adc side counts every trigger it sees
  always @(posedge core_clk) if (adc_trigger === 1'b1) trig_cnt <= trig_cnt + 8'h01;
endmodule : pofc_far_model

// ===== pofc_pkg.sv
// types shared by the pwm output stage
package pofc_pkg;
  // fault forcing state
  typedef enum logic {
    POFC_FLT_RUN,
    POFC_FLT_HOLD
  } pofc_flt_state_t;
  typedef logic [14:0] pofc_count_t;
  typedef logic [15:0] pofc_word_t;
endpackage : pofc_pkg

// ===== pofc_top.sv
// pwm output stage: pair modes, override, polarity, fault forcing, event trigger
//
// Summary of operation
// - pair mode bit set selects independent
// - independent pairs get no dead time
// - independent pins take pwm, forced low/high
// - mode 10 is edge-aligned single pulse
// - single pulse starts on run, ends on duty
// - period match clears count, run, pins; interrupt
// - force select upper byte, levels lower byte
// - forced-active low pin complements high pin
// - dead time still applies under override
// - synced overrides load at zero, center-aligned also at period
// - fuse zero drives inactive, one tri-states
// - separate polarity for high and low pins
// - cleared pin enable releases pin
// - per-pair fault enables; none leaves the pins alone, flag and interrupt still fire
// - fault level bits through pin polarity
// - latched fault needs input high and flag clear
// - cycle fault resumes at next boundary
// - lockout blocks duty and period loads
// - trigger when count equals compare value
// - phase bit picks up or down count
// - postscaler 1:1..1:16, cleared by compare write
// - fault in sleep raises wake interrupt
// - pairs reset to complementary mode
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "pofc_defines.svh"
module pofc_top (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [9:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        high_side_polarity,
  input  wire logic        low_side_polarity,
  input  wire logic        reset_pin_state_fuse,
  input  wire logic        fault_input_n,
  input  wire logic        cpu_sleep,
  output logic      [2:0]  high_side_output,
  output logic      [2:0]  low_side_output,
  output logic      [2:0]  high_side_oe,
  output logic      [2:0]  low_side_oe,
  output logic             adc_trigger,
  output logic             period_irq,
  output logic             fault_irq,
  output logic             wake_req
);

  // level as driven on the pin; pol set means active high
  function automatic logic pol_apply(input logic lvl, input logic pol);
    pol_apply = ~(lvl ^ pol);
  endfunction : pol_apply

  // counter step down, holding at zero
  function automatic pofc_pkg::pofc_count_t dec_sat(input pofc_pkg::pofc_count_t v);
    dec_sat = (v == 15'h0000) ? 15'h0000 : v - 15'h0001;
  endfunction : dec_sat

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  logic                    run_r;
  logic [1:0]              tb_mode_r;
  pofc_pkg::pofc_count_t   period_buf_r;
  pofc_pkg::pofc_count_t   period_act_r;
  logic                    evt_phase_r;
  pofc_pkg::pofc_count_t   evt_cmp_r;
  pofc_pkg::pofc_word_t    outctl_r;
  logic [3:0]              ps_sel_r;
  logic                    force_sync_r;
  logic                    lockout_r;
  logic [5:0]              dead_time_r;
  pofc_pkg::pofc_word_t    fault_ctl_r;
  pofc_pkg::pofc_word_t    force_buf_r;
  pofc_pkg::pofc_word_t    force_act_r;
  pofc_pkg::pofc_word_t    duty_buf_r [3];
  pofc_pkg::pofc_word_t    duty_act_r [3];
  // core state
  pofc_pkg::pofc_count_t   count_r;
  logic                    dir_down_r;
  logic                    claimed_r;
  logic                    hi_pol_r;
  logic                    lo_pol_r;
  logic                    flt_s1_r;
  logic                    flt_s2_r;
  logic                    flt_s3_r;
  logic                    flt_lvl_r;
  logic                    flt_flag_r;
  pofc_pkg::pofc_flt_state_t flt_state_r;
  pofc_pkg::pofc_flt_state_t flt_state_nxt;
  logic [5:0]              dt_cnt_r [3];
  logic [2:0]              h_prev_r;
  logic                    period_irq_r;
  logic                    fault_irq_r;
  logic                    wake_req_r;
  logic [2:0]              hi_out_r;
  logic [2:0]              lo_out_r;
  logic [2:0]              hi_oe_r;
  logic [2:0]              lo_oe_r;
  pofc_pkg::pofc_word_t    rdata_r;

  pofc_evt_if evt ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic wr_tbctl;
  logic wr_period;
  logic wr_evtcmp;
  logic wr_outctl;
  logic wr_secctl;
  logic wr_dtime;
  logic wr_fault;
  logic wr_force;
  logic wr_status;
  logic [2:0] wr_duty;
  assign wr_tbctl  = reg_wr && (reg_addr == `POFC_ADDR_TBCTL);
  assign wr_period = reg_wr && (reg_addr == `POFC_ADDR_PERIOD);
  assign wr_evtcmp = reg_wr && (reg_addr == `POFC_ADDR_EVTCMP);
  assign wr_outctl = reg_wr && (reg_addr == `POFC_ADDR_OUTCTL);
  assign wr_secctl = reg_wr && (reg_addr == `POFC_ADDR_SECCTL);
  assign wr_dtime  = reg_wr && (reg_addr == `POFC_ADDR_DEADTIME);
  assign wr_fault  = reg_wr && (reg_addr == `POFC_ADDR_FAULT);
  assign wr_force  = reg_wr && (reg_addr == `POFC_ADDR_FORCE);
  assign wr_status = reg_wr && (reg_addr == `POFC_ADDR_STATUS);
  assign wr_duty[0] = reg_wr && (reg_addr == `POFC_ADDR_DUTY1);
  assign wr_duty[1] = reg_wr && (reg_addr == `POFC_ADDR_DUTY2);
  assign wr_duty[2] = reg_wr && (reg_addr == `POFC_ADDR_DUTY3);

  ////////////////////////////////////////////////////////////////////////////
  // time base decode
  logic is_center;
  logic is_single;
  logic at_period;
  logic at_zero;
  logic tb_wrap;
  logic boundary;
  logic upd_pt;
  logic sync_pt;
  assign is_center = tb_mode_r[0];
  assign is_single = (tb_mode_r == `POFC_MODE_SINGLE);
  assign at_period = (count_r == period_act_r);
  assign at_zero   = (count_r == 15'h0000);
  assign tb_wrap   = ~is_center & at_period;
  // cycle or half-cycle boundary for resync and fault release
  assign boundary  = is_center ? (at_zero | at_period) : at_zero;
  // stopped time base loads buffers at once
  assign upd_pt    = ~run_r | tb_wrap | (is_center & at_zero & ~dir_down_r);
  assign sync_pt   = ~force_sync_r | boundary;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tb_mode_r    <= `POFC_MODE_FREE;
      period_buf_r <= `POFC_RST_PERIOD;
      evt_phase_r  <= 1'b0;
      evt_cmp_r    <= 15'h0000;
      outctl_r     <= `POFC_RST_OUTCTL;
      ps_sel_r     <= 4'h0;
      force_sync_r <= 1'b0;
      lockout_r    <= 1'b0;
      dead_time_r  <= 6'h00;
      fault_ctl_r  <= 16'h0000;
      force_buf_r  <= `POFC_RST_FORCE;
    end else begin
      if (wr_tbctl)  tb_mode_r    <= reg_wdata[`POFC_TB_MODE_LSB +: 2];
      if (wr_period) period_buf_r <= reg_wdata[14:0];
      if (wr_evtcmp) evt_phase_r  <= reg_wdata[`POFC_EVT_PHASE_BIT];
      if (wr_evtcmp) evt_cmp_r    <= reg_wdata[14:0];
      if (wr_outctl) outctl_r     <= reg_wdata & `POFC_OUTCTL_MASK;
      if (wr_secctl) ps_sel_r     <= reg_wdata[`POFC_PSC_LSB +: 4];
      if (wr_secctl) force_sync_r <= reg_wdata[`POFC_SYNC_BIT];
      if (wr_secctl) lockout_r    <= reg_wdata[`POFC_LOCK_BIT];
      if (wr_dtime)  dead_time_r  <= reg_wdata[5:0];
      if (wr_fault)  fault_ctl_r  <= reg_wdata & `POFC_FAULT_MASK;
      if (wr_force)  force_buf_r  <= reg_wdata & `POFC_FORCE_MASK;
    end
  end

  // duty buffers
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        duty_buf_r[i] <= 16'h0000;
      end else if (wr_duty[i]) begin
        duty_buf_r[i] <= reg_wdata;
      end
    end
  end

  // buffer transfer; lockout freezes the active copies
  always_ff @(posedge core_clk) begin
    if (rst) begin
      period_act_r <= `POFC_RST_PERIOD;
      for (int i = 0; i < 3; i++) duty_act_r[i] <= 16'h0000;
    end else if (upd_pt && !lockout_r) begin
      period_act_r <= period_buf_r;
      for (int i = 0; i < 3; i++) duty_act_r[i] <= duty_buf_r[i];
    end
  end

  // override copy, optionally held until a boundary
  always_ff @(posedge core_clk) begin
    if (rst) begin
      force_act_r <= `POFC_RST_FORCE;
    end else if (sync_pt) begin
      force_act_r <= force_buf_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run bit: software write wins over the single-pulse clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_r <= 1'b0;
    end else if (wr_tbctl) begin
      run_r <= reg_wdata[`POFC_TB_RUN_BIT];
    end else if (is_single && run_r && at_period) begin
      run_r <= 1'b0;
    end
  end

  // time base counter; holds its value while stopped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_r    <= 15'h0000;
      dir_down_r <= 1'b0;
    end else if (run_r && !is_center) begin
      count_r    <= at_period ? 15'h0000 : count_r + 15'h0001;
      dir_down_r <= 1'b0;
    end else if (run_r && !dir_down_r) begin
      count_r    <= at_period ? dec_sat(count_r) : count_r + 15'h0001;
      dir_down_r <= at_period;
    end else if (run_r) begin
      count_r    <= dec_sat(count_r);
      dir_down_r <= (count_r > 15'h0001);
    end
  end

  // single-pulse end interrupt
  always_ff @(posedge core_clk) begin
    if (rst) begin
      period_irq_r <= 1'b0;
    end else begin
      period_irq_r <= is_single & run_r & at_period;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault pin: three stages, level moves once the last two agree
  logic flt_fall;
  logic flt_now;
  logic flt_release;
  assign flt_fall    = flt_lvl_r & ~flt_s2_r & ~flt_s3_r;
  assign flt_now     = ~flt_lvl_r & (|fault_ctl_r[`POFC_FLT_EN_LSB +: 3]);
  // latched mode also waits for software to clear the flag
  assign flt_release = flt_lvl_r & boundary &
                       (fault_ctl_r[`POFC_FLT_MODE_BIT] | ~flt_flag_r);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flt_s1_r  <= 1'b1;
      flt_s2_r  <= 1'b1;
      flt_s3_r  <= 1'b1;
      flt_lvl_r <= 1'b1;
    end else begin
      flt_s1_r  <= fault_input_n;
      flt_s2_r  <= flt_s1_r;
      flt_s3_r  <= flt_s2_r;
      if (flt_s2_r == flt_s3_r) flt_lvl_r <= flt_s3_r;
    end
  end

  // sticky flag: a new fault beats a write-one clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flt_flag_r <= 1'b0;
    end else if (flt_fall) begin
      flt_flag_r <= 1'b1;
    end else if (wr_status && reg_wdata[`POFC_ST_FLAG_BIT]) begin
      flt_flag_r <= 1'b0;
    end
  end

  // pulses to the interrupt controller and the wake logic
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_irq_r <= 1'b0;
      wake_req_r  <= 1'b0;
    end else begin
      fault_irq_r <= flt_fall;
      wake_req_r  <= flt_fall & cpu_sleep;
    end
  end

  // fault forcing state
  always_comb begin
    flt_state_nxt = flt_state_r;
    unique case (flt_state_r)
      pofc_pkg::POFC_FLT_RUN:  if (flt_now) flt_state_nxt = pofc_pkg::POFC_FLT_HOLD;
      pofc_pkg::POFC_FLT_HOLD: if (flt_release) flt_state_nxt = pofc_pkg::POFC_FLT_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) flt_state_r <= pofc_pkg::POFC_FLT_RUN;
    else     flt_state_r <= flt_state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pair output path
  logic [2:0] raw;
  logic [2:0] h_src;
  logic [2:0] l_src;
  logic [2:0] dt_clear;
  logic [2:0] h_fin;
  logic [2:0] l_fin;
  logic [2:0] hi_en;
  logic [2:0] lo_en;
  logic       flt_hold;
  assign flt_hold = (flt_state_r == pofc_pkg::POFC_FLT_HOLD);
  assign hi_en    = outctl_r[`POFC_HI_EN_LSB +: 3];
  assign lo_en    = outctl_r[`POFC_LO_EN_LSB +: 3];

  for (genvar i = 0; i < 3; i++) begin : g_pair
    logic indep;
    logic sel_h;
    logic sel_l;
    logic lv_h;
    logic lv_l;
    logic flt_pair;
    assign indep    = outctl_r[`POFC_PAIR_MODE_LSB + i];
    assign sel_h    = force_act_r[`POFC_FORCE_SEL_LSB + 2*i + 1];
    assign sel_l    = force_act_r[`POFC_FORCE_SEL_LSB + 2*i];
    assign lv_h     = force_act_r[`POFC_FORCE_LVL_LSB + 2*i + 1];
    assign lv_l     = force_act_r[`POFC_FORCE_LVL_LSB + 2*i];
    assign flt_pair = flt_hold & fault_ctl_r[`POFC_FLT_EN_LSB + i];
    // duty compare; single pulse only while running
    assign raw[i]   = ({1'b0, count_r} < duty_act_r[i]) & (run_r | ~is_single);
    assign h_src[i] = sel_h ? lv_h : raw[i];
    // independent pins share one duty; complementary low mirrors high
    assign l_src[i] = indep ? (sel_l ? lv_l : raw[i])
                            : (sel_l ? (lv_l & ~h_src[i]) : ~h_src[i]);
    // complementary pairs idle both pins while the dead-time counter runs
    assign dt_clear[i] = indep | ((dt_cnt_r[i] == 6'h00) && (h_src[i] == h_prev_r[i]));
    // fault level outranks the override
    assign h_fin[i] = flt_pair ? fault_ctl_r[`POFC_FLT_LVL_LSB + 2*i + 1]
                               : (h_src[i] & dt_clear[i]);
    assign l_fin[i] = flt_pair ? fault_ctl_r[`POFC_FLT_LVL_LSB + 2*i]
                               : (l_src[i] & dt_clear[i]);
  end : g_pair

  // dead-time counters reload on every high-side edge
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        dt_cnt_r[i] <= 6'h00;
        h_prev_r[i] <= 1'b0;
      end else begin
        h_prev_r[i] <= h_src[i];
        if (h_src[i] != h_prev_r[i]) dt_cnt_r[i] <= dead_time_r;
        else if (dt_cnt_r[i] != 6'h00) dt_cnt_r[i] <= dt_cnt_r[i] - 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers; polarity and fuse are caught while reset is held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hi_pol_r  <= high_side_polarity;
      lo_pol_r  <= low_side_polarity;
      claimed_r <= ~reset_pin_state_fuse;
      hi_out_r  <= {3{pol_apply(1'b0, high_side_polarity)}};
      lo_out_r  <= {3{pol_apply(1'b0, low_side_polarity)}};
      hi_oe_r   <= {3{~reset_pin_state_fuse}};
      lo_oe_r   <= {3{~reset_pin_state_fuse}};
    end else begin
      // tri-stated pins wait for software to claim them
      if (wr_outctl) claimed_r <= 1'b1;
      for (int i = 0; i < 3; i++) begin
        hi_out_r[i] <= pol_apply(h_fin[i], hi_pol_r);
        lo_out_r[i] <= pol_apply(l_fin[i], lo_pol_r);
      end
      hi_oe_r <= hi_en & {3{claimed_r}};
      lo_oe_r <= lo_en & {3{claimed_r}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // special event trigger
  logic phase_ok;
  assign phase_ok  = ~is_center | (dir_down_r == evt_phase_r);
  assign evt.match = run_r & (count_r == evt_cmp_r) & phase_ok;
  assign evt.ps_sel = ps_sel_r;
  assign evt.clr   = wr_evtcmp;

  pofc_event_trig u_event_trig (
    .core_clk (core_clk),
    .rst      (rst),
    .evt      (evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read back; unmapped addresses read zero
  pofc_pkg::pofc_word_t rd_val;
  pofc_pkg::pofc_word_t st_val;
  assign st_val = {12'h000, run_r, flt_lvl_r, flt_hold, flt_flag_r};
  assign rd_val =
    (reg_addr == `POFC_ADDR_TBCTL)    ? {run_r, 13'h0000, tb_mode_r} :
    (reg_addr == `POFC_ADDR_COUNT)    ? {dir_down_r, count_r} :
    (reg_addr == `POFC_ADDR_PERIOD)   ? {1'b0, period_buf_r} :
    (reg_addr == `POFC_ADDR_EVTCMP)   ? {evt_phase_r, evt_cmp_r} :
    (reg_addr == `POFC_ADDR_OUTCTL)   ? outctl_r :
    (reg_addr == `POFC_ADDR_SECCTL)   ? {4'h0, ps_sel_r, 6'h00, force_sync_r, lockout_r} :
    (reg_addr == `POFC_ADDR_DEADTIME) ? {10'h000, dead_time_r} :
    (reg_addr == `POFC_ADDR_FAULT)    ? fault_ctl_r :
    (reg_addr == `POFC_ADDR_FORCE)    ? force_buf_r :
    (reg_addr == `POFC_ADDR_DUTY1)    ? duty_buf_r[0] :
    (reg_addr == `POFC_ADDR_DUTY2)    ? duty_buf_r[1] :
    (reg_addr == `POFC_ADDR_DUTY3)    ? duty_buf_r[2] :
    (reg_addr == `POFC_ADDR_STATUS)   ? st_val : 16'h0000;

  always_ff @(posedge core_clk) begin
    if (rst) rdata_r <= 16'h0000;
    else     rdata_r <= reg_rd ? rd_val : 16'h0000;
  end

  assign reg_rdata        = rdata_r;
  assign high_side_output = hi_out_r;
  assign low_side_output  = lo_out_r;
  assign high_side_oe     = hi_oe_r;
  assign low_side_oe      = lo_oe_r;
  assign adc_trigger      = evt.trig;
  assign period_irq       = period_irq_r;
  assign fault_irq        = fault_irq_r;
  assign wake_req         = wake_req_r;

endmodule : pofc_top

// ===== pofc_top_checker.sv
// port assertions for the pwm output stage
`timescale 1ns/1ps
module pofc_top_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [9:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        high_side_polarity,
  input wire logic        low_side_polarity,
  input wire logic        reset_pin_state_fuse,
  input wire logic        cpu_sleep,
  input wire logic [2:0]  high_side_output,
  input wire logic [2:0]  low_side_output,
  input wire logic [2:0]  high_side_oe,
  input wire logic [2:0]  low_side_oe,
  input wire logic        adc_trigger,
  input wire logic        period_irq,
  input wire logic        fault_irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge core_clk);
  endclocking
  // bus answers: data only after a read, nothing from holes
  chk_rdata_idle: assert property (disable iff (rst) !$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data without a read");
  chk_hole_zero: assert property (disable iff (rst)
    reg_rd && reg_addr == 10'h3FE |=> reg_rdata == 16'h0)
    else $error("unmapped read returned data");
  // pins are registered, so reset shows one edge late
  chk_rst_oe: assert property ($past(rst) |->
    high_side_oe == {3{!$past(reset_pin_state_fuse)}} &&
    low_side_oe == {3{!$past(reset_pin_state_fuse)}})
    else $error("pin enables wrong in reset");
  chk_rst_level: assert property ($past(rst) |->
    high_side_output == {3{!$past(high_side_polarity)}} &&
    low_side_output == {3{!$past(low_side_polarity)}})
    else $error("pins not inactive in reset");
  chk_rst_quiet: assert property ($past(rst) |->
    !adc_trigger && !period_irq && !fault_irq && !wake_req)
    else $error("pulse during reset");
  // pulses last exactly one cycle; wake only with a fault interrupt while asleep
  chk_irq_pulse: assert property (disable iff (rst) period_irq |=> !period_irq)
    else $error("period interrupt longer than a cycle");
  chk_trig_pulse: assert property (disable iff (rst) adc_trigger |=> !adc_trigger)
    else $error("adc trigger longer than a cycle");
  chk_flt_pulse: assert property (disable iff (rst) fault_irq |=> !fault_irq)
    else $error("fault interrupt longer than a cycle");
  chk_wake_sleep: assert property (disable iff (rst)
    wake_req |-> fault_irq && $past(cpu_sleep))
    else $error("wake without sleeping fault");
endmodule : pofc_top_checker
bind pofc_top pofc_top_checker pofc_top_checker_inst (.core_clk, .rst, .reg_addr, .reg_rd,
  .reg_rdata, .high_side_polarity, .low_side_polarity, .reset_pin_state_fuse, .cpu_sleep,
  .high_side_output, .low_side_output, .high_side_oe, .low_side_oe, .adc_trigger,
  .period_irq, .fault_irq, .wake_req);

// ===== tb_top.sv
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`include "pofc_defines.svh"
module tb_top;
  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic [9:0]  reg_addr  = 10'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        cpu_sleep = 1'b0;
  logic        flt_low   = 1'b0;
  logic [15:0] reg_rdata;
  logic [2:0]  hso, lso, hoe, loe, hs_pad, ls_pad;
  logic        fault_input_n, adc_trigger, period_irq, fault_irq, wake_req;
  logic [7:0]  trig_cnt, t0;
  logic [3:0]  ev;
  int          failures   = 0;
  int          n_compared = 0;
  assign ev = {wake_req, period_irq, fault_irq, adc_trigger};
  always #4 core_clk = ~core_clk;
  // polarity and fuse are fixed straps
  pofc_top pofc_top_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .high_side_polarity(1'b1), .low_side_polarity(1'b1),
    .reset_pin_state_fuse(1'b1), .fault_input_n, .cpu_sleep, .high_side_output(hso),
    .low_side_output(lso), .high_side_oe(hoe), .low_side_oe(loe), .adc_trigger,
    .period_irq, .fault_irq, .wake_req);
  pofc_far_model pofc_far_model_inst (.core_clk, .flt_low, .high_side_output(hso),
    .low_side_output(lso), .high_side_oe(hoe), .low_side_oe(loe), .adc_trigger,
    .fault_input_n, .hs_pad, .ls_pad, .trig_cnt);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask : rd
  // force copy lands next edge, pin one edge later
  task automatic pads(input logic [5:0] e);
    repeat (3) @(posedge core_clk);
    #1;
    chk("pads", {10'h0, e}, {10'h0, hs_pad, ls_pad});
  endtask : pads
  task automatic wait_ev(input int b);
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      #1;
      if (ev[b] === 1'b1) return;
    end
    failures++;
    $display("unexpected timeout event %0d exp 1 got 0", b);
    summarize();
  endtask : wait_ev
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("oe", 16'h0000, {10'h0, hoe, loe});
    rd(`POFC_ADDR_OUTCTL, 16'h0077);
    rd(`POFC_ADDR_FORCE, 16'h3F00);
    rd(`POFC_ADDR_PERIOD, 16'h3FFF);
    rd(10'h3FE, 16'h0000);
    // independent pairs, high pin of pair 1 released
    wr(`POFC_ADDR_OUTCTL, 16'h0767);
    rd(`POFC_ADDR_OUTCTL, 16'h0767);
    chk("oe", 16'h0037, {10'h0, hoe, loe});
    wr(`POFC_ADDR_FORCE, 16'h3F15);
    pads(6'h07);
    wr(`POFC_ADDR_FORCE, 16'h3F2A);
    pads(6'h30);
    // latched fault while asleep, levels inactive, beats the override
    wr(`POFC_ADDR_FAULT, 16'h0007);
    cpu_sleep <= 1'b1;
    flt_low   <= 1'b1;
    wait_ev(3);
    cpu_sleep <= 1'b0;
    pads(6'h00);
    flt_low <= 1'b0;
    repeat (12) @(posedge core_clk);
    pads(6'h00);
    wr(`POFC_ADDR_STATUS, 16'h0001);
    pads(6'h30);
    rd(`POFC_ADDR_STATUS, 16'h0004);
    // single pulse with one event match
    wr(`POFC_ADDR_FORCE, 16'h0000);
    wr(`POFC_ADDR_DUTY1, 16'h0003);
    wr(`POFC_ADDR_PERIOD, 16'h0008);
    wr(`POFC_ADDR_EVTCMP, 16'h0005);
    wr(`POFC_ADDR_TBCTL, 16'h8002);
    wait_ev(2);
    rd(`POFC_ADDR_TBCTL, 16'h0002);
    chk("triggers", 16'h0001, {8'h0, trig_cnt});
    // free run, four matches through a 1:2 postscaler
    wr(`POFC_ADDR_SECCTL, 16'h0100);
    wr(`POFC_ADDR_EVTCMP, 16'h0005);
    t0 = trig_cnt;
    wr(`POFC_ADDR_TBCTL, 16'h8000);
    repeat (34) @(posedge core_clk);
    wr(`POFC_ADDR_TBCTL, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1;
    chk("triggers", 16'h0002, {8'h0, trig_cnt - t0});
    // stopped at zero: locked duty write must not reach the pins
    wr(`POFC_ADDR_SECCTL, 16'h0101);
    wr(`POFC_ADDR_DUTY2, 16'h0005);
    pads(6'h01);
    wr(`POFC_ADDR_SECCTL, 16'h0100);
    pads(6'h13);
    summarize();
  end
endmodule : tb_top
